//--- hdl/axil_regs_pkg.sv
// Shared constants for the register access slave
package axil_regs_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int CTRL_WORDS = 4;
    localparam int STAT_WORDS = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_EXOKAY = 2'h1;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [31:0] CTRL_BASE = 32'h00000000;
    localparam logic [31:0] STAT_BASE = 32'h00000400;
    localparam logic [31:0] TICK_COUNT_ADDR = 32'h00000500;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
endpackage : axil_regs_pkg

//--- hdl/byte_lane_merge.sv
// Byte-lane merge of a write word into a stored word
module byte_lane_merge (
    input wire logic [31:0] old_i,
    input wire logic [31:0] new_i,
    input wire logic [3:0] strb_i,
    output logic [31:0] merged_o
);
    genvar g;
    generate
        for (g = 0; g < axil_regs_pkg::STRB_W; g++) begin : g_lane
            assign merged_o[g*8 +: 8] = strb_i[g] ? new_i[g*8 +: 8]
                                                  : old_i[g*8 +: 8];
        end
    endgenerate
endmodule : byte_lane_merge

//--- hdl/axil_register_access_fsm.sv
// Register slave answering single reads and writes over AXI4-Lite
// Functional notes
// - Illegal write address answers slave error
// - Illegal read address answers slave error
// - One clock, synchronous active-low reset
// - Strobes update only selected byte lanes
// - Data and address buses are 32 bits
// - Write response valid only with response
// - Mapped writes set core control ports
// - Mapped reads return status and statistics
module axil_register_access_fsm (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic perf_monitor_tick_in_i,
    input wire logic [31:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [31:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic [127:0] status_i,
    output logic [127:0] control_o
);
    typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_t;
    typedef enum logic [1:0] {R_IDLE, R_DATA} rd_state_t;

    wr_state_t wst_q, wst_d;
    rd_state_t rst_q, rst_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] ctrl_q [axil_regs_pkg::CTRL_WORDS];
    logic [31:0] ctrl_d [axil_regs_pkg::CTRL_WORDS];
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic [31:0] merged;
    logic [1:0] widx;
    logic [1:0] ridx;
    logic w_ctrl_hit;
    logic r_ctrl_hit;
    logic r_stat_hit;
    logic r_tick_hit;

    // Word index within each window
    assign widx = awaddr_i[3:2];
    assign ridx = araddr_i[3:2];
    assign w_ctrl_hit = (awaddr_i[31:4] == axil_regs_pkg::CTRL_BASE[31:4])
                        && (awaddr_i[1:0] == 2'h0);
    assign r_ctrl_hit = (araddr_i[31:4] == axil_regs_pkg::CTRL_BASE[31:4])
                        && (araddr_i[1:0] == 2'h0);
    assign r_stat_hit = (araddr_i[31:4] == axil_regs_pkg::STAT_BASE[31:4])
                        && (araddr_i[1:0] == 2'h0);
    assign r_tick_hit = (araddr_i == axil_regs_pkg::TICK_COUNT_ADDR);

    byte_lane_merge u_merge (
        .old_i(ctrl_q[widx]),
        .new_i(wdata_i),
        .strb_i(wstrb_i),
        .merged_o(merged)
    );

    // Write channel: take address and data together, then respond
    always_comb begin
        wst_d = wst_q;
        awready_d = 1'b0;
        wready_d = 1'b0;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        for (int i = 0; i < axil_regs_pkg::CTRL_WORDS; i++) begin
            ctrl_d[i] = ctrl_q[i];
        end
        unique case (wst_q)
            W_IDLE: begin
                // Ready pulses one cycle after both valids seen
                if (awvalid_i && wvalid_i && !awready_q) begin
                    awready_d = 1'b1;
                    wready_d = 1'b1;
                end
                if (awready_q) begin
                    if (w_ctrl_hit) begin
                        ctrl_d[widx] = merged;
                        bresp_d = axil_regs_pkg::RESP_OKAY;
                    end else begin
                        bresp_d = axil_regs_pkg::RESP_SLVERR;
                    end
                    bvalid_d = 1'b1;
                    wst_d = W_RESP;
                end
            end
            W_RESP: begin
                // Response held until taken
                if (bready_i) begin
                    bvalid_d = 1'b0;
                    bresp_d = axil_regs_pkg::RESP_OKAY;
                    wst_d = W_IDLE;
                end
            end
            default: begin
                wst_d = W_IDLE;
                bvalid_d = 1'b0;
            end
        endcase
    end

    // Read channel
    always_comb begin
        rst_d = rst_q;
        arready_d = 1'b0;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        unique case (rst_q)
            R_IDLE: begin
                if (arvalid_i && !arready_q) begin
                    arready_d = 1'b1;
                end
                if (arready_q) begin
                    rvalid_d = 1'b1;
                    rresp_d = axil_regs_pkg::RESP_OKAY;
                    if (r_ctrl_hit) begin
                        rdata_d = ctrl_q[ridx];
                    end else if (r_stat_hit) begin
                        rdata_d = status_i[ridx*32 +: 32];
                    end else if (r_tick_hit) begin
                        rdata_d = tick_cnt_q;
                    end else begin
                        rdata_d = 32'h00000000;
                        rresp_d = axil_regs_pkg::RESP_SLVERR;
                    end
                    rst_d = R_DATA;
                end
            end
            R_DATA: begin
                if (rready_i) begin
                    rvalid_d = 1'b0;
                    rresp_d = axil_regs_pkg::RESP_OKAY;
                    rst_d = R_IDLE;
                end
            end
            default: begin
                rst_d = R_IDLE;
                rvalid_d = 1'b0;
            end
        endcase
    end

    // Statistics counter of monitor ticks
    always_comb begin
        tick_cnt_d = tick_cnt_q;
        if (perf_monitor_tick_in_i) begin
            tick_cnt_d = tick_cnt_q + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wst_q <= W_IDLE;
            rst_q <= R_IDLE;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= axil_regs_pkg::RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= axil_regs_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
            tick_cnt_q <= 32'h00000000;
            for (int i = 0; i < axil_regs_pkg::CTRL_WORDS; i++) begin
                ctrl_q[i] <= axil_regs_pkg::CTRL_RESET;
            end
        end else begin
            wst_q <= wst_d;
            rst_q <= rst_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            tick_cnt_q <= tick_cnt_d;
            for (int i = 0; i < axil_regs_pkg::CTRL_WORDS; i++) begin
                ctrl_q[i] <= ctrl_d[i];
            end
        end
    end

    assign awready_o = awready_q;
    assign wready_o = wready_q;
    assign bvalid_o = bvalid_q;
    assign bresp_o = bresp_q;
    assign arready_o = arready_q;
    assign rvalid_o = rvalid_q;
    assign rresp_o = rresp_q;
    assign rdata_o = rdata_q;

    genvar g;
    generate
        for (g = 0; g < axil_regs_pkg::CTRL_WORDS; g++) begin : g_ctrl
            assign control_o[g*32 +: 32] = ctrl_q[g];
        end
    endgenerate
endmodule : axil_register_access_fsm

//--- test/axil_regs_assertions.sv
// Handshake checks on the register access slave ports
module axil_regs_assertions (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [31:0] awaddr_i,
    input wire logic awvalid_i,
    input wire logic awready_o,
    input wire logic wvalid_i,
    input wire logic wready_o,
    input wire logic [1:0] bresp_o,
    input wire logic bvalid_o,
    input wire logic bready_i,
    input wire logic [31:0] araddr_i,
    input wire logic arvalid_i,
    input wire logic arready_o,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] rresp_o,
    input wire logic rvalid_o,
    input wire logic rready_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence wr_take_s;
        awvalid_i && wvalid_i && !awready_o && !bvalid_o ##1 awready_o;
    endsequence
    sequence rd_take_s;
        arvalid_i && !arready_o && !rvalid_o ##1 arready_o;
    endsequence
    aw_w_pair_a: assert property (awready_o == wready_o)
        else $error("ready split");
    wr_resp_a: assert property (wr_take_s |=> bvalid_o)
        else $error("no write response");
    b_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o &&
        $stable(bresp_o)) else $error("response dropped");
    bad_wr_a: assert property (wr_take_s ##0 awaddr_i[1:0] != 2'h0 |=>
        bresp_o == axil_regs_pkg::RESP_SLVERR) else $error("no slverr");
    rd_resp_a: assert property (rd_take_s |=> rvalid_o)
        else $error("no read data");
    r_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o &&
        $stable(rdata_o) && $stable(rresp_o)) else $error("read dropped");
    bad_rd_a: assert property (rd_take_s ##0 araddr_i[1:0] != 2'h0 |=>
        rresp_o == axil_regs_pkg::RESP_SLVERR && rdata_o == 32'h0)
        else $error("no read slverr");
    r_drop_a: assert property (rvalid_o && rready_i |=> !rvalid_o)
        else $error("read repeated");
endmodule : axil_regs_assertions

bind axil_register_access_fsm axil_regs_assertions chk (.*);

//--- test/axil_user_master.sv
// User request machine acting as bus master
module axil_user_master (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic rd_req_i,
    input wire logic wr_req_i,
    input wire logic slow_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [31:0] req_data_i,
    input wire logic [3:0] req_strb_i,
    output logic [31:0] awaddr_i,
    output logic awvalid_i,
    output logic [31:0] wdata_i,
    output logic [3:0] wstrb_i,
    output logic wvalid_i,
    output logic bready_i,
    output logic [31:0] araddr_i,
    output logic arvalid_i,
    output logic rready_i,
    input wire logic awready_o,
    input wire logic [1:0] bresp_o,
    input wire logic bvalid_o,
    input wire logic arready_o,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] rresp_o,
    input wire logic rvalid_o,
    output logic done_o,
    output logic [1:0] resp_o,
    output logic [31:0] got_data_o
);
    typedef enum logic [1:0] {IDLE, WRITE, READ, ACK} st_t;
    st_t st_q;
    logic sent_q;
    assign awvalid_i = st_q == WRITE && !sent_q;
    assign wvalid_i = awvalid_i;
    assign awaddr_i = awvalid_i ? req_addr_i : ~req_addr_i;
    assign wdata_i = awvalid_i ? req_data_i : ~req_data_i;
    assign wstrb_i = awvalid_i ? req_strb_i : ~req_strb_i;
    assign arvalid_i = st_q == READ && !sent_q;
    assign araddr_i = arvalid_i ? req_addr_i : ~req_addr_i;
    assign bready_i = st_q == WRITE && !slow_i;
    assign rready_i = st_q == READ && !slow_i;
    assign done_o = st_q == ACK;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_q <= IDLE;
            sent_q <= 1'b0;
        end else begin
            sent_q <= st_q != IDLE && (sent_q || awready_o || arready_o);
            case (st_q)
                IDLE: if (rd_req_i) st_q <= READ;
                      else if (wr_req_i) st_q <= WRITE;
                WRITE: if (bvalid_o && bready_i) begin
                    st_q <= ACK;
                    resp_o <= bresp_o;
                end
                READ: if (rvalid_o && rready_i) begin
                    st_q <= ACK;
                    resp_o <= rresp_o;
                    got_data_o <= rdata_o;
                end
                default: st_q <= IDLE;
            endcase
        end
    end
endmodule : axil_user_master

//--- test/tb_top.sv
// Self-checking bench for the register access slave
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, reset_n_i, perf_monitor_tick_in_i, awvalid_i, awready_o;
    logic wvalid_i, wready_o, bvalid_o, bready_i, arvalid_i, arready_o;
    logic rvalid_o, rready_i, rd_req_i, wr_req_i, slow_i, done_o;
    logic [31:0] awaddr_i, wdata_i, araddr_i, rdata_o, got_data_o;
    logic [31:0] req_addr_i, req_data_i;
    logic [3:0] wstrb_i, req_strb_i;
    logic [1:0] bresp_o, rresp_o, resp_o;
    logic [127:0] status_i, control_o;
    int fails = 0;
    int total_checks = 0;
    axil_register_access_fsm dut (.*);
    axil_user_master master (.*);
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One request; a slow one stalls the ready for five cycles
    task automatic xfer(input logic rd, input logic [31:0] a, d,
                        input logic [3:0] s, input logic sl);
        int n = 0;
        @(posedge clk_i);
        {rd_req_i, wr_req_i, slow_i} <= {rd, !rd, sl};
        {req_addr_i, req_data_i, req_strb_i} <= {a, d, s};
        @(posedge clk_i);
        {rd_req_i, wr_req_i} <= 2'h0;
        repeat (40) begin
            @(negedge clk_i);
            if (done_o === 1'b1) break;
            @(posedge clk_i);
            if (++n == 5) slow_i <= 1'b0;
        end
        chk({31'h0, done_o}, 32'h1);
    endtask : xfer
    task automatic test_ctrl;
        xfer(0, 32'h4, 32'hA5A51234, 4'hF, 1);
        chk({30'h0, resp_o}, 32'h0);
        xfer(0, 32'h4, 32'hFFFFFFFF, 4'h2, 0);
        chk(control_o[63:32], 32'hA5A5FF34);
        xfer(0, 32'hC, 32'h5A5AC3C3, 4'hF, 0);
        chk(control_o[127:96], 32'h5A5AC3C3);
        chk(control_o[95:64], 32'h0);
        xfer(1, 32'h4, 32'h0, 4'h0, 1);
        chk(got_data_o, 32'hA5A5FF34);
        $display("test ctrl done");
    endtask : test_ctrl
    task automatic test_status;
        status_i <= {32'h0, 32'h13579BDF, 64'h0};
        xfer(1, 32'h408, 32'h0, 4'h0, 0);
        chk(got_data_o, 32'h13579BDF);
        repeat (3) begin
            @(posedge clk_i) perf_monitor_tick_in_i <= 1'b1;
            @(posedge clk_i) perf_monitor_tick_in_i <= 1'b0;
        end
        xfer(1, 32'h500, 32'h0, 4'h0, 0);
        chk(got_data_o, 32'h3);
        $display("test status done");
    endtask : test_status
    task automatic test_errors;
        xfer(0, 32'h404, 32'hFFFFFFFF, 4'hF, 1);
        chk({30'h0, resp_o}, 32'h2);
        xfer(0, 32'h2, 32'hFFFFFFFF, 4'hF, 0);
        chk({30'h0, resp_o}, 32'h2);
        chk(control_o[31:0], 32'h0);
        xfer(1, 32'h3, 32'h0, 4'h0, 1);
        chk({30'h0, resp_o}, 32'h2);
        xfer(1, 32'h600, 32'h0, 4'h0, 0);
        chk({30'h0, resp_o}, 32'h2);
        chk(got_data_o, 32'h0);
        $display("test errors done");
    endtask : test_errors
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        {reset_n_i, perf_monitor_tick_in_i, rd_req_i, wr_req_i} = 4'h0;
        {slow_i, req_strb_i, req_addr_i, req_data_i} = '0;
        status_i = '0;
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        test_ctrl();
        test_status();
        test_errors();
        end_sim();
    end
    initial begin
        #100000;
        fails++;
        end_sim();
    end
endmodule : tb_top
